// [logic/active_power_params.svh]
// Constants of the active power to frequency datapath.
// Assumes inclusion from the package and the datapath module only.
`ifndef ACTIVE_POWER_PARAMS_SVH
`define ACTIVE_POWER_PARAMS_SVH

// Sample and datapath widths
`define SAMPLE_W 24
`define POWER_W 32
`define ACC_W 56
// Product bits dropped to form the power word
`define PRODUCT_DROP 17
// Dc tracking speed of the current high-pass filter (2^-n per sample)
`define HPF_SHIFT 10
// Lag added to undo the high-pass phase lead
`define PHASE_SHIFT 6
// 2^-14 per sample at a 450 kHz sampler gives a corner near 4.5 Hz
`define LPF_SHIFT 14
`define LPF_STATE_W 46
// Slow threshold is 2^(49 - rate select): each select step doubles the rate
`define SLOW_THR_LOG 6'h31
// Calibration ratio is 2^(6 + scale - select), or 2^11 in the special case
`define CF_BASE_SHIFT 4'h6
`define CF_MAX_SHIFT 4'hB
// Pulse widths in sampler ticks
`define SLOW_PULSE_TICKS 8'h10
`define CF_PULSE_TICKS 8'h02
// Buffer depth
`define BUF_DEPTH 2

`endif

// [logic/active_power_pkg.sv]
// Types shared by the active power to frequency datapath.
// Assumes the constants header is on the include path.
`include "active_power_params.svh"

package active_power_pkg;

	// One converted sample pair
	typedef struct packed {
		logic signed [`SAMPLE_W-1:0] current;
		logic signed [`SAMPLE_W-1:0] voltage;
	} sample_pair_t;

	// Rate configuration caught from the select pins
	typedef struct packed {
		logic scale;
		logic [1:0] rate;
	} rate_cfg_t;

endpackage

// [logic/active_power_to_frequency.sv]
// Active power to frequency datapath: high-pass, multiply, low-pass, pulse accumulators.
// Assumes converter samples arrive on the core clock; select pins and sampler clock are asynchronous.
`timescale 1ns/1ps
`include "active_power_params.svh"

//Contract
// [R01] Current samples pass a dc-removing high-pass filter before multiplication.
// [R02] Instantaneous power is the filtered current times the voltage, each sample.
// [R03] Power is low-pass filtered, single pole, corner near 4.5 Hz.
// [R04] The high-pass phase shift is compensated up to 1 kHz.
// [R05] The converter integrates filtered power and pulses proportionally, averaging ripple.
// [R06] Slow outputs accumulate over long periods and so carry almost no ripple.
// [R07] Calibration output accumulates far less, up to 2048 times the slow rate.
// [R08] Counting equipment averages the calibration pulse rate to remove ripple.
// [R09] An external counter sums slow pulses to obtain active energy.
// [R10] Slow outputs pulse high; two selects pick one of four binary rates.
// [R11] Selects and calibration scale set the calibration ratio, 128 down to 16, or 2048.
// [R12] Sampling follows the sampler clock input derived from the oscillator.
// [R13] Accumulators keep the remainder after each pulse so no energy is lost.
// [R14] One clock, one synchronous reset; pulse outputs low during reset.
module active_power_to_frequency
	import active_power_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic sampler_clock_input,
	input wire logic rate_select_lsb,
	input wire logic rate_select_msb,
	input wire logic calibration_scale_select,
	input wire sample_pair_t sampleIn,
	input wire logic sampleValid,
	output logic sampleReady,
	output logic slow_pulse_out_a,
	output logic slow_pulse_out_b,
	output logic calibration_pulse_out
);

	// Pin synchronisers
	logic [2:0] sclkSyncFf;
	rate_cfg_t cfgMetaFf;
	rate_cfg_t cfgFf;
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sclkSyncFf <= 3'h0;
			cfgMetaFf <= '0;
			cfgFf <= '0;
		end else begin
			sclkSyncFf <= {sclkSyncFf[1:0], sampler_clock_input};
			cfgMetaFf <= '{scale: calibration_scale_select, rate: {rate_select_msb, rate_select_lsb}};
			cfgFf <= cfgMetaFf;
		end
	end
	wire tick = sclkSyncFf[1] & ~sclkSyncFf[2]; // R12

	// Two-entry sample buffer; the datapath drains one entry per sampler tick
	sample_pair_t bufMemFf [`BUF_DEPTH];
	logic wrPtrFf;
	logic rdPtrFf;
	logic [1:0] countFf;
	wire push = sampleValid & sampleReady;
	wire pop = tick & (countFf != 2'h0); // R12
	wire [1:0] nxt_count = 2'(countFf + {1'b0, push} - {1'b0, pop});
	generate
		for (genvar e = 0; e < `BUF_DEPTH; e++) begin : gEntry
			always_ff @(posedge clock) begin
				if (push && wrPtrFf == 1'(e)) begin
					bufMemFf[e] <= sampleIn;
				end
			end
		end
	endgenerate
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wrPtrFf <= 1'b0;
			rdPtrFf <= 1'b0;
			countFf <= 2'h0;
			sampleReady <= 1'b0;
		end else begin
			wrPtrFf <= wrPtrFf ^ push;
			rdPtrFf <= rdPtrFf ^ pop;
			countFf <= nxt_count;
			sampleReady <= (nxt_count != 2'h2);
		end
	end
	sample_pair_t head;
	assign head = bufMemFf[rdPtrFf];

	// High-pass filter with phase compensation on the current channel
	logic signed [`SAMPLE_W-1:0] dcFf;
	logic signed [`SAMPLE_W:0] hpPrevFf;
	logic signed [`SAMPLE_W:0] iFiltFf;
	logic signed [`SAMPLE_W-1:0] vFf;
	logic s1ValidFf;
	wire signed [`SAMPLE_W:0] hpRaw = {head.current[`SAMPLE_W-1], head.current} - {dcFf[`SAMPLE_W-1], dcFf}; // R01
	wire signed [`SAMPLE_W:0] hpStep = hpRaw - hpPrevFf;
	wire signed [`SAMPLE_W:0] hpComp = hpRaw - (hpStep >>> `PHASE_SHIFT); // R04
	wire signed [`SAMPLE_W-1:0] nxt_dc = `SAMPLE_W'(dcFf + `SAMPLE_W'(hpRaw >>> `HPF_SHIFT)); // R01
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			dcFf <= '0;
			hpPrevFf <= '0;
			iFiltFf <= '0;
			vFf <= '0;
			s1ValidFf <= 1'b0;
		end else begin
			s1ValidFf <= pop;
			if (pop) begin
				dcFf <= nxt_dc;
				hpPrevFf <= hpRaw;
				iFiltFf <= hpComp;
				vFf <= head.voltage;
			end
		end
	end

	// Multiplier
	logic signed [`POWER_W-1:0] powerFf;
	logic s2ValidFf;
	wire signed [2*`SAMPLE_W:0] product = iFiltFf * vFf; // R02
	wire signed [`POWER_W-1:0] powerW = product[`PRODUCT_DROP+`POWER_W-1:`PRODUCT_DROP];
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			powerFf <= '0;
			s2ValidFf <= 1'b0;
		end else begin
			s2ValidFf <= s1ValidFf;
			if (s1ValidFf) begin
				powerFf <= powerW; // R02
			end
		end
	end

	// Single-pole low-pass filter; state holds power scaled by 2^LPF_SHIFT
	logic signed [`LPF_STATE_W-1:0] lpfStateFf;
	logic s3ValidFf;
	wire signed [`POWER_W-1:0] lpfOut = lpfStateFf[`LPF_STATE_W-1:`LPF_SHIFT];
	wire signed [`LPF_STATE_W-1:0] nxt_lpfState =
		`LPF_STATE_W'(lpfStateFf + `LPF_STATE_W'(powerFf) - `LPF_STATE_W'(lpfOut)); // R03
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			lpfStateFf <= '0;
			s3ValidFf <= 1'b0;
		end else begin
			s3ValidFf <= s2ValidFf;
			if (s2ValidFf) begin
				lpfStateFf <= nxt_lpfState; // R03
			end
		end
	end

	// Digital-to-frequency accumulators; negative power adds nothing
	wire [`ACC_W-1:0] addend = lpfOut[`POWER_W-1] ? '0 : `ACC_W'(lpfOut); // R05
	wire specialRatio = (cfgFf.rate == 2'h3) && !cfgFf.scale; // R07
	wire [3:0] cfShift = specialRatio ? `CF_MAX_SHIFT :
		4'(`CF_BASE_SHIFT + {3'h0, cfgFf.scale} - {2'h0, cfgFf.rate}); // R11
	wire [`ACC_W-1:0] slowThr = `ACC_W'(1) << (`SLOW_THR_LOG - {4'h0, cfgFf.rate}); // R10
	wire [`ACC_W-1:0] cfThr = slowThr >> cfShift; // R11
	logic [`ACC_W-1:0] slowAccFf;
	logic [`ACC_W-1:0] cfAccFf;
	wire [`ACC_W-1:0] slowSum = slowAccFf + addend; // R06
	wire [`ACC_W-1:0] cfSum = cfAccFf + addend; // R07
	wire slowHit = s3ValidFf && (slowSum >= slowThr);
	wire cfHit = s3ValidFf && (cfSum >= cfThr);
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			slowAccFf <= '0;
			cfAccFf <= '0;
		end else if (s3ValidFf) begin
			slowAccFf <= slowHit ? slowSum - slowThr : slowSum; // R13
			cfAccFf <= cfHit ? cfSum - cfThr : cfSum; // R13
		end
	end

	// Pulse stretchers; slow pulses alternate between the two slow outputs
	logic [7:0] slowCntFf;
	logic [7:0] cfCntFf;
	logic slowPhaseFf;
	wire [7:0] nxt_slowCnt = slowHit ? `SLOW_PULSE_TICKS : 8'((slowCntFf != 8'h0 && tick) ? slowCntFf - 8'h1 : slowCntFf);
	wire [7:0] nxt_cfCnt = cfHit ? `CF_PULSE_TICKS : 8'((cfCntFf != 8'h0 && tick) ? cfCntFf - 8'h1 : cfCntFf);
	wire nxt_slowPhase = slowPhaseFf ^ slowHit;
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			slowCntFf <= 8'h0;
			cfCntFf <= 8'h0;
			slowPhaseFf <= 1'b0;
			slow_pulse_out_a <= 1'b0; // R14
			slow_pulse_out_b <= 1'b0;
			calibration_pulse_out <= 1'b0;
		end else begin
			slowCntFf <= nxt_slowCnt;
			cfCntFf <= nxt_cfCnt;
			slowPhaseFf <= nxt_slowPhase;
			slow_pulse_out_a <= (nxt_slowCnt != 8'h0) && nxt_slowPhase; // R10
			slow_pulse_out_b <= (nxt_slowCnt != 8'h0) && !nxt_slowPhase;
			calibration_pulse_out <= (nxt_cfCnt != 8'h0); // R07
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	AST_HPF_TAKES_SAMPLE: assert property (pop |=> s1ValidFf && dcFf == $past(nxt_dc)) // R01
		else $error("high-pass state did not follow the popped sample");
	AST_PRODUCT: assert property (s1ValidFf |=> s2ValidFf && powerFf == $past(powerW)) // R02
		else $error("power word is not the product of the channels");
	AST_LPF_HOLD: assert property (!s2ValidFf |=> $stable(lpfStateFf)) // R03
		else $error("low-pass state moved without a power sample");
	AST_PHASE_COMP: assert property (pop |=> iFiltFf == $past(hpComp)) // R04
		else $error("compensated current missing");
	AST_SPECIAL_RATIO: assert property (cfgFf == rate_cfg_t'{scale: 1'b0, rate: 2'h3} |-> cfThr == (slowThr >> 11)) // R07
		else $error("calibration ratio 2048 not applied");
	AST_RATIO_RANGE: assert property (!specialRatio |-> cfShift >= 4'h4 && cfShift <= 4'h7) // R11
		else $error("calibration ratio outside 16 to 128");
	AST_SLOW_PULSE: assert property (slowHit |=> slow_pulse_out_a ^ slow_pulse_out_b) // R10
		else $error("slow hit produced no pulse");
	AST_REMAINDER: assert property (slowHit |=> slowAccFf == $past(slowSum) - $past(slowThr)) // R13
		else $error("slow remainder not kept");
	AST_TICK_ONLY: assert property (s1ValidFf |-> $past(tick)) // R12
		else $error("sample processed without a sampler tick");
	// Reset itself is the antecedent, so the default disable must not apply here
	AST_RESET_LOW: assert property (@(posedge clock) disable iff (1'b0) // R14
		!rst_b |=> !slow_pulse_out_a && !slow_pulse_out_b && !calibration_pulse_out)
		else $error("pulse output high after reset");
	AST_CF_PULSE: assert property (cfHit |=> calibration_pulse_out) // R07
		else $error("calibration hit produced no pulse");
	AST_CF_REMAINDER: assert property (cfHit |=> cfAccFf == $past(cfSum) - $past(cfThr)) // R13
		else $error("calibration remainder not kept");
	AST_NO_REVERSE: assert property (s3ValidFf && lpfOut[`POWER_W-1] && !cfHit && !slowHit |=> // R05
		$stable(cfAccFf) && $stable(slowAccFf))
		else $error("negative power moved an accumulator");

endmodule

// [testbench/pulse_counter_model.sv]
// Pulse counter at the pulse outputs, standing in for a meter register or a frequency counter.
// Assumes the outputs are sampled on the core clock and clear is driven by the bench.
`timescale 1ns/1ps
module pulse_counter_model (
	input wire logic clock,
	input wire logic clear,
	input wire logic slow_pulse_out_a,
	input wire logic slow_pulse_out_b,
	input wire logic calibration_pulse_out,
	output int slowCount,
	output int calCount
);
	logic slowA_ff = 1'b0;
	logic slowB_ff = 1'b0;
	logic cal_ff = 1'b0;
	always @(posedge clock) begin
		slowA_ff <= slow_pulse_out_a;
		slowB_ff <= slow_pulse_out_b;
		cal_ff <= calibration_pulse_out;
		if (clear) begin
			slowCount <= 0;
			calCount <= 0;
		end else begin
			// Rising edges only, so a stretched pulse counts once
			slowCount <= slowCount + int'(slow_pulse_out_a && !slowA_ff) + int'(slow_pulse_out_b && !slowB_ff);
			calCount <= calCount + int'(calibration_pulse_out && !cal_ff);
		end
	end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the active power to frequency datapath.
// Assumes the package, the datapath and the pulse counter model are compiled first.
`timescale 1ns/1ps
module tb_top
	import active_power_pkg::*;
;
	logic clock = 1'b0, rst_b = 1'b0, sampler_clock_input = 1'b0, tickOn = 1'b0, clear = 1'b1, anti = 1'b0;
	logic rate_select_lsb = 1'b0, rate_select_msb = 1'b0, calibration_scale_select = 1'b0, sampleValid = 1'b0;
	logic sampleReady, slowA, slowB, calOut;
	logic [1:0] div = 2'h0;
	sample_pair_t sampleIn = '0;
	int idx = 0, miscompares = 0, cmp_count = 0, slowCount, calCount, calRef;

	active_power_to_frequency dut_u (.clock(clock), .rst_b(rst_b), .sampler_clock_input(sampler_clock_input),
		.rate_select_lsb(rate_select_lsb), .rate_select_msb(rate_select_msb),
		.calibration_scale_select(calibration_scale_select), .sampleIn(sampleIn), .sampleValid(sampleValid),
		.sampleReady(sampleReady), .slow_pulse_out_a(slowA), .slow_pulse_out_b(slowB), .calibration_pulse_out(calOut));
	pulse_counter_model model_u (.clock(clock), .clear(clear), .slow_pulse_out_a(slowA), .slow_pulse_out_b(slowB),
		.calibration_pulse_out(calOut), .slowCount(slowCount), .calCount(calCount));

	// Full-scale square wave; voltage in phase or in antiphase with current
	function automatic sample_pair_t word(input int n, input logic inv);
		sample_pair_t w;
		w.current = n[4] ? -24'sh7F_FFFF : 24'sh7F_FFFF;
		w.voltage = inv ? -w.current : w.current;
		return w;
	endfunction

	always #2 clock = ~clock;
	always @(posedge clock) begin
		if (sampleValid && sampleReady) begin
			idx <= idx + 1;
			sampleIn <= word(idx + 1, anti);
		end
		if (tickOn) begin
			div <= div + 2'h1;
			sampler_clock_input <= div[1];
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic wait_ready(input logic lvl);
		int n;
		n = 0;
		while (sampleReady !== lvl) begin
			@(posedge clock);
			#1;
			n++;
			if (n > 40) begin
				miscompares++;
				$display("unexpected sampleReady wait expected %h seen %h", lvl, sampleReady);
				end_sim();
			end
		end
	endtask

	task automatic do_reset(input logic scl, input logic [1:0] rate, input logic inv);
		@(posedge clock);
		sampleValid <= 1'b0;
		@(posedge clock);
		rst_b <= 1'b0;
		clear <= 1'b1;
		tickOn <= 1'b0;
		anti <= inv;
		idx <= 0;
		sampleIn <= word(0, inv);
		calibration_scale_select <= scl;
		{rate_select_msb, rate_select_lsb} <= rate;
		repeat (5) @(posedge clock);
		#1;
		chk("outputs in reset", 4'h0, {sampleReady, slowA, slowB, calOut});
		@(posedge clock);
		rst_b <= 1'b1;
		clear <= 1'b0;
		@(posedge clock);
		#1;
		chk("sampleReady after reset", 1'h1, sampleReady);
	endtask

	task automatic run_power(input logic scl, input logic [1:0] rate, input logic inv);
		do_reset(scl, rate, inv);
		@(posedge clock);
		sampleValid <= 1'b1;
		tickOn <= 1'b1;
		repeat (16000) @(posedge clock);
		#1;
	endtask

	task automatic t_buffer();
		do_reset(1'b0, 2'h3, 1'b0);
		@(posedge clock);
		sampleValid <= 1'b1;
		wait_ready(1'b0);
		chk("words held when full", 8'h02, idx);
		@(posedge clock);
		tickOn <= 1'b1;
		wait_ready(1'b1);
		$display("buffer test done");
	endtask

	task automatic t_inphase();
		run_power(1'b0, 2'h3, 1'b0);
		calRef = calCount;
		chk("cal pulses seen", 1'h1, calCount > 0);
		chk("slow pulses against cal", 1'h1, slowCount * 64 <= calCount);
		$display("in phase test done");
	endtask

	task automatic t_anti();
		run_power(1'b0, 2'h3, 1'b1);
		chk("cal pulses negative power", 8'h00, calCount);
		chk("slow pulses negative power", 8'h00, slowCount);
		$display("antiphase test done");
	endtask

	task automatic t_scale();
		run_power(1'b1, 2'h3, 1'b0);
		chk("cal count at scale one", 1'h1, calCount * 16 < calRef);
		$display("scale test done");
	endtask

	initial begin
		t_buffer();
		t_inphase();
		t_anti();
		t_scale();
		end_sim();
	end
endmodule
